//--- src/analog_input_scaling.v
/*
 * Analog input scaling: per-channel offset, multiply and divide of raw
 * converter counts, with the object entries that hold the factors.
 * Assumes the converter and the object access port run on core_clk and
 * that the persistent store saves and restores entries through that port.
 */
`timescale 1ns/1ps
`include "analog_input_scaling_defs.vh"

module analog_input_scaling (
   input  wire        core_clk,
   input  wire        srst,
   input  wire        adc_valid,
   input  wire        adc_channel,
   input  wire [9:0]  adc_count,
   input  wire        od_req,
   input  wire        od_write,
   input  wire [15:0] od_index,
   input  wire [7:0]  od_subindex,
   input  wire [31:0] od_wdata,
   output reg         od_ack,
   output reg         od_error,
   output reg  [31:0] od_rdata,
   output reg  [31:0] tx_result_ch1,
   output reg  [31:0] tx_result_ch2
);

   // Factor entries live in the channel slices; the store saves and
   // restores them over this same access port
   wire [15:0] offset_ch1;
   wire [15:0] offset_ch2;
   wire [15:0] mult_ch1;
   wire [15:0] mult_ch2;
   wire [15:0] div_ch1;
   wire [15:0] div_ch2;

   // Quotient of each slice and whether it may be published
   wire        load_ch1;
   wire        load_ch2;
   wire [31:0] value_ch1;
   wire [31:0] value_ch2;

   // Object access decode
   wire sub_ch1  = (od_subindex == `AIS_SUB_CH1);
   wire sub_ch2  = (od_subindex == `AIS_SUB_CH2);
   wire sub_cnt  = (od_subindex == `AIS_SUB_COUNT);
   wire sub_ok   = sub_ch1 | sub_ch2 | sub_cnt;
   wire idx_res  = (od_index == `AIS_IDX_RESULT);
   wire idx_off  = (od_index == `AIS_IDX_OFFSET);
   wire idx_mul  = (od_index == `AIS_IDX_MULTIPLIER);
   wire idx_div  = (od_index == `AIS_IDX_DIVISOR);
   wire idx_fac  = idx_off | idx_mul | idx_div;
   wire wr_ok    = od_req & od_write & idx_fac & (sub_ch1 | sub_ch2);

   reg [31:0] next_rdata;
   reg        next_error;

   always @* begin
      next_rdata = 32'h00000000;
      next_error = 1'b0;
      if (!(idx_res | idx_fac) || !sub_ok) begin
         next_error = 1'b1;
      end else if (od_write && (idx_res || sub_cnt)) begin
         next_error = 1'b1;
      end else if (sub_cnt) begin
         next_rdata = {24'h000000, `AIS_CHANNEL_COUNT};
      end else if (idx_res) begin
         next_rdata = sub_ch2 ? tx_result_ch2 : tx_result_ch1;
      end else if (idx_off) begin
         next_rdata = sub_ch2 ? {{16{offset_ch2[15]}}, offset_ch2}
                              : {{16{offset_ch1[15]}}, offset_ch1};
      end else if (idx_mul) begin
         next_rdata = sub_ch2 ? {{16{mult_ch2[15]}}, mult_ch2}
                              : {{16{mult_ch1[15]}}, mult_ch1};
      end else begin
         next_rdata = sub_ch2 ? {{16{div_ch2[15]}}, div_ch2}
                              : {{16{div_ch1[15]}}, div_ch1};
      end
   end

   // Per-slice write strobes; refused accesses never reach a slice
   wire wr_off_ch1 = wr_ok & idx_off & sub_ch1;
   wire wr_off_ch2 = wr_ok & idx_off & sub_ch2;
   wire wr_mul_ch1 = wr_ok & idx_mul & sub_ch1;
   wire wr_mul_ch2 = wr_ok & idx_mul & sub_ch2;
   wire wr_div_ch1 = wr_ok & idx_div & sub_ch1;
   wire wr_div_ch2 = wr_ok & idx_div & sub_ch2;

   scaling_channel #(
      .CHANNEL (1'b0)
   ) u_ch1 (
      .core_clk       (core_clk),
      .srst           (srst),
      .sample_valid   (adc_valid),
      .sample_channel (adc_channel),
      .sample_count   (adc_count),
      .write_offset   (wr_off_ch1),
      .write_mult     (wr_mul_ch1),
      .write_div      (wr_div_ch1),
      .write_value    (od_wdata[15:0]),
      .offset         (offset_ch1),
      .multiplier     (mult_ch1),
      .divisor        (div_ch1),
      .result_load    (load_ch1),
      .result_value   (value_ch1)
   );

   scaling_channel #(
      .CHANNEL (1'b1)
   ) u_ch2 (
      .core_clk       (core_clk),
      .srst           (srst),
      .sample_valid   (adc_valid),
      .sample_channel (adc_channel),
      .sample_count   (adc_count),
      .write_offset   (wr_off_ch2),
      .write_mult     (wr_mul_ch2),
      .write_div      (wr_div_ch2),
      .write_value    (od_wdata[15:0]),
      .offset         (offset_ch2),
      .multiplier     (mult_ch2),
      .divisor        (div_ch2),
      .result_load    (load_ch2),
      .result_value   (value_ch2)
   );

   always @(posedge core_clk) begin
      if (srst) begin
         od_ack   <= 1'b0;
         od_error <= 1'b0;
         od_rdata <= `AIS_RDATA_RESET;
      end else begin
         od_ack   <= od_req;
         od_error <= od_req & next_error;
         if (od_req) begin
            od_rdata <= next_rdata;
         end
      end
   end

   // Results stay in converter digits under the preset factors, so
   // volts and milliamps follow the scale figures; a zero divisor
   // leaves the old value standing
   always @(posedge core_clk) begin
      if (srst) begin
         tx_result_ch1 <= `AIS_RESULT_RESET;
         tx_result_ch2 <= `AIS_RESULT_RESET;
      end else begin
         if (load_ch1) begin
            tx_result_ch1 <= value_ch1;
         end
         if (load_ch2) begin
            tx_result_ch2 <= value_ch2;
         end
      end
   end

endmodule

// One input channel: factor entries, product stage and divide.
// The product stage gives the divide a full cycle; the divisor is read
// at the divide, so a divisor write in between already applies.
module scaling_channel #(
   parameter [0:0] CHANNEL = 1'b0
) (
   input  wire        core_clk,
   input  wire        srst,
   input  wire        sample_valid,
   input  wire        sample_channel,
   input  wire [9:0]  sample_count,
   input  wire        write_offset,
   input  wire        write_mult,
   input  wire        write_div,
   input  wire [15:0] write_value,
   output reg  [15:0] offset,
   output reg  [15:0] multiplier,
   output reg  [15:0] divisor,
   output wire        result_load,
   output wire [31:0] result_value
);
   reg               prod_valid;
   reg signed [33:0] prod;

   wire               take      = sample_valid & (sample_channel == CHANNEL);
   wire signed [17:0] corrected =
      $signed({8'h00, sample_count}) + $signed({{2{offset[15]}}, offset});
   wire signed [33:0] next_prod = corrected * $signed(multiplier);
   wire signed [33:0] wide_div  = $signed({{18{divisor[15]}}, divisor});
   wire signed [33:0] quotient  = prod / wide_div;

   assign result_load  = prod_valid & (divisor != 16'h0000);
   assign result_value = quotient[31:0];

   always @(posedge core_clk) begin
      if (srst) begin
         offset     <= `AIS_OFFSET_RESET;
         multiplier <= `AIS_MULT_RESET;
         divisor    <= `AIS_DIV_RESET;
         prod_valid <= 1'b0;
         prod       <= `AIS_PROD_RESET;
      end else begin
         if (write_offset) begin
            offset <= write_value;
         end
         if (write_mult) begin
            multiplier <= write_value;
         end
         if (write_div) begin
            divisor <= write_value;
         end
         prod_valid <= take;
         if (take) begin
            prod <= next_prod;
         end
      end
   end

endmodule

//--- src/analog_input_scaling_defs.vh
/*
 * Constants of the analog input scaling block: object indices, subindices,
 * reset presets and the converter scale figures.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef ANALOG_INPUT_SCALING_DEFS_VH
`define ANALOG_INPUT_SCALING_DEFS_VH

// Object indices
`define AIS_IDX_RESULT      16'h3320
`define AIS_IDX_OFFSET      16'h3321
`define AIS_IDX_MULTIPLIER  16'h3322
`define AIS_IDX_DIVISOR     16'h3323

// Subindices
`define AIS_SUB_COUNT       8'h00
`define AIS_SUB_CH1         8'h01
`define AIS_SUB_CH2         8'h02

// Presets
`define AIS_CHANNEL_COUNT   8'h02
`define AIS_OFFSET_RESET    16'h0000
`define AIS_MULT_RESET      16'h0001
`define AIS_DIV_RESET       16'h0001
`define AIS_RESULT_RESET    32'h00000000
`define AIS_RDATA_RESET     32'h00000000
`define AIS_PROD_RESET      34'h000000000

// Converter scale: volts = (x - 512) * 20 / 1023, mA = x * 20 / 1023
`define AIS_ADC_WIDTH       10
`define AIS_ADC_MIDSCALE    10'h200
`define AIS_ADC_FULLSCALE   10'h3FF
`define AIS_FULL_VOLTS      20
`define AIS_FULL_MILLIAMPS  20

`endif

//--- verification/adc_model.sv
/* Converter model: raw counts on request.
   Assumes requests change at the falling edge. */
`timescale 1ns/1ps
module adc_model (
   input  wire       core_clk,
   input  wire       trig,
   input  wire       ch,
   input  wire [9:0] cnt,
   output wire       adc_valid,
   output wire       adc_channel,
   output wire [9:0] adc_count
);
   reg [9:0] last = 10'h000;
   always @(posedge core_clk) if (trig) last <= cnt;
   assign adc_valid   = trig;
   // Stale lines inverted so unqualified use shows
   assign adc_channel = trig ? ch : ~ch;
   assign adc_count   = trig ? cnt : ~last;
endmodule

//--- verification/ais_checker.sv
/* Checker of object port timing and result hold.
   Assumes binding onto analog_input_scaling. */
`timescale 1ns/1ps
module ais_checker (
   input wire        core_clk,
   input wire        srst,
   input wire        adc_valid,
   input wire        adc_channel,
   input wire        od_req,
   input wire        od_write,
   input wire [15:0] od_index,
   input wire [7:0]  od_subindex,
   input wire        od_ack,
   input wire        od_error,
   input wire [31:0] od_rdata,
   input wire [31:0] tx_result_ch1
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   wire wr = od_req && od_write;
   AST_ACK: assert property (od_req |=> od_ack) else $error("missing ack");
   AST_NOACK: assert property (!od_req |=> !od_ack) else $error("stray ack");
   AST_RO: assert property (wr && od_index == 16'h3320 |=> od_error)
      else $error("result write taken");
   AST_SUB0: assert property (wr && od_subindex == 8'h00 |=> od_error)
      else $error("count write taken");
   AST_CNT: assert property (od_req && !od_write && od_subindex == 8'h00 &&
      od_index[15:2] == 14'h0CC8 |=> od_rdata == 32'h00000002) else $error("bad count");
   AST_ERRZ: assert property (od_error |-> od_ack && od_rdata == 32'h00000000)
      else $error("bad refusal");
   AST_OFS: assert property (wr && od_index == 16'h3321 && od_subindex == 8'h01
      |=> !od_error) else $error("offset write refused");
   AST_HOLD: assert property (!$past(adc_valid && !adc_channel, 2)
      |-> $stable(tx_result_ch1)) else $error("result moved");
   cover property (od_error);
   cover property (adc_valid && adc_channel);
   cover property (od_req ##1 od_req);
endmodule
bind analog_input_scaling ais_checker u_chk (.core_clk, .srst, .adc_valid, .adc_channel,
   .od_req, .od_write, .od_index, .od_subindex, .od_ack, .od_error, .od_rdata, .tx_result_ch1);

//--- verification/analog_input_scaling_test.sv
/* Bench: object reads checked against queued notes.
   Assumes the converter model and the bound checker. */
`timescale 1ns/1ps
module analog_input_scaling_test;
   reg          core_clk = 1'b0;
   reg          srst = 1'b1;
   reg          od_req = 1'b0, od_write = 1'b0, trig = 1'b0, ch = 1'b0;
   reg   [15:0] od_index = 16'h0000;
   reg   [7:0]  od_subindex = 8'h00;
   reg   [31:0] od_wdata = 32'h00000000;
   reg   [9:0]  cnt = 10'h000;
   wire         adc_valid, adc_channel, od_ack, od_error;
   wire  [9:0]  adc_count;
   wire  [31:0] od_rdata, tx_result_ch1, tx_result_ch2;
   logic [32:0] notes[$];
   logic [31:0] rnd = 32'h00007DD9;
   int          n_fail = 0;
   int          tests_run = 0;
   always #5 core_clk = ~core_clk;
   adc_model u_adc (.core_clk, .trig, .ch, .cnt, .adc_valid, .adc_channel, .adc_count);
   analog_input_scaling u_dut (.core_clk, .srst, .adc_valid, .adc_channel, .adc_count,
      .od_req, .od_write, .od_index, .od_subindex, .od_wdata, .od_ack, .od_error,
      .od_rdata, .tx_result_ch1, .tx_result_ch2);
   function logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function logic [31:0] scl(input int c, o, m, d);
      return ((c + o) * m) / d;
   endfunction
   task chk(input logic [32:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
            input logic [32:0] e);
      @(negedge core_clk);
      {od_req, od_write, od_index, od_subindex, od_wdata, trig} = {1'b1, w, i, s, d, 1'b0};
      notes.push_back(e);
   endtask
   task smp(input logic c, input logic [9:0] v);
      @(negedge core_clk);
      {od_req, trig, ch, cnt} = {1'b0, 1'b1, c, v};
   endtask
   task idle;
      @(negedge core_clk);
      {od_req, trig} = 2'b00;
      repeat (3) @(negedge core_clk);
   endtask
   task print_verdict;
      $display("compared %0d, mismatched %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(negedge core_clk) if (od_ack === 1'b1) chk({od_error, od_rdata}, notes.pop_front());
   initial begin
      int o, m, d;
      logic [31:0] r;
      repeat (6) @(negedge core_clk);
      srst = 1'b0;
      for (int i = 0; i < 4; i++)
         for (int s = 0; s < 3; s++)
            acc(0, 16'h3320 + 16'(i), 8'(s), 0, s == 0 ? 33'h2 : 33'(i > 1));
      idle();
      $display("test presets done");
      rnd = lfsr(rnd);
      smp(0, rnd[9:0]);
      idle();
      acc(0, 16'h3320, 1, 0, {23'h000000, rnd[9:0]});
      o = int'($signed(rnd[7:0]));
      m = int'(rnd[11:8]) - 8;
      d = int'(rnd[14:12]) + 1;
      acc(1, 16'h3321, 2, o, 0);
      acc(1, 16'h3322, 2, m, 33'h1);
      acc(1, 16'h3323, 2, d, 33'h1);
      acc(0, 16'h3322, 2, 0, {1'b0, 32'(m)});
      smp(1, rnd[31:22]);
      idle();
      r = scl(rnd[31:22], o, m, d);
      acc(0, 16'h3320, 2, 0, {1'b0, r});
      chk({1'b0, tx_result_ch2}, {1'b0, r});
      $display("test scaling done");
      acc(1, 16'h3320, 1, 5, 33'h100000000);
      acc(1, 16'h3321, 0, 5, 33'h100000000);
      acc(0, 16'h3321, 3, 0, 33'h100000000);
      acc(0, 16'h3324, 1, 0, 33'h100000000);
      acc(1, 16'h3323, 2, 0, {1'b0, 32'(d)});
      smp(1, ~rnd[31:22]);
      idle();
      acc(0, 16'h3320, 2, 0, {1'b0, r});
      idle();
      $display("test refusals done");
      rnd = lfsr(rnd);
      acc(1, 16'h3321, 1, 32'hFFFFFE00, 0);
      acc(1, 16'h3322, 1, 20, 33'h1);
      acc(1, 16'h3323, 1, 1023, 33'h1);
      smp(0, rnd[9:0]);
      idle();
      acc(0, 16'h3320, 1, 0, {1'b0, scl(rnd[9:0], -512, 20, 1023)});
      acc(1, 16'h3321, 1, 0, 33'hFFFFFE00);
      smp(0, rnd[19:10]);
      idle();
      acc(0, 16'h3320, 1, 0, {1'b0, scl(rnd[19:10], 0, 20, 1023)});
      idle();
      $display("test unit scales done");
      srst = 1'b1;
      repeat (2) @(negedge core_clk);
      srst = 1'b0;
      acc(0, 16'h3322, 1, 0, 33'h1);
      acc(0, 16'h3320, 1, 0, 33'h0);
      idle();
      $display("test mid-run reset done");
      for (int k = 0; k < 20 && notes.size() > 0; k++) @(negedge core_clk);
      if (notes.size() > 0) n_fail++;
      print_verdict();
   end
endmodule
